/* File: psc_pkg.sv */
// Purpose: shared constants for the product sign punch and check block
// Assumes: card cycle positions counted in tenths of an index point
// Notes:   positions are decoded from one cycle-position counter that stops with the feed
package psc_pkg;
  // card cycle geometry, in tenths of an index point
  localparam int unsigned POS_W         = 8;
  localparam logic [7:0]  CYCLE_TENTHS  = 8'hA0;  // 16.0 index points per card cycle
  localparam logic [7:0]  X_TIME_POS    = 8'h6E;  // 11.0, the X row under the brushes
  localparam logic [7:0]  FLAG_HOLD_POS = 8'h32;  // 5.0, end of factor flag hold
  localparam logic [7:0]  PICKUP_POS    = 8'h43;  // 6.7, delay pickup point
  localparam logic [7:0]  DELAY_END_POS = 8'h73;  // 11.5, end of delay hold
  // default clock cycles per tenth of an index point
  localparam int unsigned TICK_DIV_DEF  = 4;
  // apb register byte offsets
  localparam logic [3:0]  OFF_CTRL   = 4'h0;
  localparam logic [3:0]  OFF_STATUS = 4'h4;
  localparam logic [3:0]  OFF_CMD    = 4'h8;
  localparam logic [3:0]  OFF_POS    = 4'hC;
  // control register fields
  localparam int unsigned CTRL_W       = 4;
  localparam int unsigned CTRL_SIGN_EN = 0;
  localparam int unsigned CTRL_CHECK   = 1;
  localparam int unsigned CTRL_REVERSE = 2;
  localparam int unsigned CTRL_RUN     = 3;
  localparam logic [3:0]  CTRL_RST     = 4'h0;
  // command register field
  localparam int unsigned CMD_ERR_RESET = 0;
endpackage : psc_pkg

/* File: psc_idx_if.sv */
// Purpose: carries cycle position and index-point events between modules
// Assumes: every event is a single clock-cycle pulse
// Notes:   source is the position counter, sink is the sign logic
interface psc_idx_if;
  logic [7:0] pos;            // current position, tenths
  logic       x_evt;          // x time
  logic       hold_end_evt;   // 5.0
  logic       pickup_evt;     // 6.7
  logic       delay_end_evt;  // 11.5
  logic       cycle_end_evt;  // last tenth of the cycle
  modport src (output pos, x_evt, hold_end_evt, pickup_evt, delay_end_evt, cycle_end_evt);
  modport snk (input  pos, x_evt, hold_end_evt, pickup_evt, delay_end_evt, cycle_end_evt);
endinterface : psc_idx_if

/* File: psc_index_counter.sv */
// Purpose: card cycle position counter with single-tick cam events
// Assumes: run_in stays high while the card feed turns
// Notes:   each cam event fires on the one clock that enters its position; cycle end fires on the last clock of 15.9
module psc_index_counter
  import psc_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_DIV_DEF
)(
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // feed running
  input  wire logic run_in,
  // events
  psc_idx_if.src    idx
);
  logic [15:0] div_q;  // clocks within one tenth
  logic [7:0]  pos_q;  // position in tenths
  wire         step  = run_in && (div_q == 16'(TICK_DIV - 1));
  wire         first = run_in && (div_q == 16'h0000);
  wire         wrap  = step && (pos_q == CYCLE_TENTHS - 8'h01);

  // divider and position; the counter freezes while the feed is stopped
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      div_q <= 16'h0000;
      pos_q <= 8'h00;
    end
    else if (run_in)
    begin
      div_q <= step ? 16'h0000 : div_q + 16'h0001;
      if (step)
        pos_q <= wrap ? 8'h00 : pos_q + 8'h01;
    end
  end

  // cam decodes, one tick each
  assign idx.pos           = pos_q;
  assign idx.x_evt         = first && (pos_q == X_TIME_POS);
  assign idx.hold_end_evt  = first && (pos_q == FLAG_HOLD_POS);
  assign idx.pickup_evt    = first && (pos_q == PICKUP_POS);
  assign idx.delay_end_evt = first && (pos_q == DELAY_END_POS);
  assign idx.cycle_end_evt = wrap;
endmodule : psc_index_counter

/* File: psc_sign_top.sv */
// Purpose: product sign punch and sign check logic with apb control
// Assumes: brush inputs are high while a hole is under the brush
// Notes:   apb writes take no wait state, reads one; one card cycle per wrap
//
// Function
// - X in assigned column marks factor negative
// - product negative when exactly one factor negative
// - enabled sign gate at X time qualifies all
// - factor flags set at X, hold to 5.0
// - delay flag picks at 6.7 on odd count
// - delay flag holds until 11.5 then clears
// - punch mode fires product X at X time
// - check with reversal swaps factor sign inputs
// - check mode product X flag joins the vote
// - check mode sign disagreement stops and flags error
// - check delay, then check error, then error latch
// - stop only at end of second-brush cycle
// - error latch holds until error reset pressed
// - rate card cycle blocks error latch pickup
module psc_sign_top
  import psc_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_DIV_DEF
)(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // apb slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [31:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // first brush station
  input  wire logic        multiplicand_sign_in,
  input  wire logic        multiplier_sign_in,
  input  wire logic        product_sign_check_in,
  // machine controls
  input  wire logic        rate_card_suppress_in,
  input  wire logic        error_reset_in,
  // punch and machine state
  output logic             product_sign_punch_out,
  output logic             machine_stop_out,
  output logic             error_light_out,
  output logic             feed_run_out
);
  psc_idx_if idx ();  // cycle position events

  logic [CTRL_W-1:0] ctrl_q;          // software control bits
  logic [31:0]       prdata_q;        // read data register
  logic              rd_ack_q;        // read data stands, pready in second access cycle
  logic              first_flag_q;    // first_factor_negative_flag
  logic              second_flag_q;   // second_factor_negative_flag
  logic              prod_flag_q;     // product_negative_flag
  logic              sign_pending_q;  // vote caught as factor flags drop
  logic              sign_delay_q;    // sign_delay_flag
  logic              punch_q;         // product sign punch pulse
  logic              check_delay_q;   // check_delay_flag
  logic              check_pend_q;    // check delay caught at 5.0
  logic              check_error_q;   // check_error_flag
  logic              err_latch_q;     // machine_error_latch
  logic              stop_q;          // machine halted on error

  // control decode
  wire sign_enable      = ctrl_q[CTRL_SIGN_EN];
  wire check_mode_relay = ctrl_q[CTRL_CHECK];
  wire factor_reversal  = ctrl_q[CTRL_REVERSE];
  wire feed_run         = ctrl_q[CTRL_RUN] && !stop_q;

  // the gate is the x_time_cam qualified by the enable switch
  wire sign_gate = sign_enable && idx.x_evt;

  // reversal only acts in check mode, swapping the factor columns
  wire swap_in    = check_mode_relay && factor_reversal;
  wire first_sel  = swap_in ? multiplier_sign_in : multiplicand_sign_in;
  wire second_sel = swap_in ? multiplicand_sign_in : multiplier_sign_in;

  // an X under its own wired column sets each factor flag
  wire first_set  = sign_gate && first_sel;
  wire second_set = sign_gate && second_sel;
  // product X counts only while checking
  wire prod_set   = sign_gate && check_mode_relay && product_sign_check_in;

  // either factor flag held, used by the switch-off check
  wire factor_flags = first_flag_q || second_flag_q;

  // odd count of negatives: factors differ, or disagree with product X
  wire sign_vote = first_flag_q ^ second_flag_q ^ prod_flag_q;

  // punch in punch mode, check-delay in check mode
  wire punch_fire = sign_gate && sign_delay_q && !check_mode_relay;
  wire check_fire = sign_gate && sign_delay_q && check_mode_relay;

  // error latch pickup, blocked while a rate card passes
  wire err_set = sign_gate && check_error_q && !rate_card_suppress_in;

  // apb decode
  wire        apb_acc    = psel_in && penable_in;
  wire        apb_wr     = apb_acc && pwrite_in;
  // a read is registered in its first access cycle and answered in the next
  wire        apb_rd_take = apb_acc && !pwrite_in && !rd_ack_q;
  wire [3:0]  apb_off    = paddr_in[3:0];
  wire        hit_ctrl   = (paddr_in[31:4] == 28'h0000000) && (apb_off == OFF_CTRL);
  wire        hit_status = (paddr_in[31:4] == 28'h0000000) && (apb_off == OFF_STATUS);
  wire        hit_cmd    = (paddr_in[31:4] == 28'h0000000) && (apb_off == OFF_CMD);
  wire        hit_pos    = (paddr_in[31:4] == 28'h0000000) && (apb_off == OFF_POS);
  wire        apb_hit    = hit_ctrl || hit_status || hit_cmd || hit_pos;
  wire        err_clr    = error_reset_in || (apb_wr && hit_cmd && pwdata_in[CMD_ERR_RESET]);

  // status word: flags in the low bits, machine state above
  wire [31:0] status_word = {20'h00000, stop_q, err_latch_q, check_error_q, check_pend_q,
                             check_delay_q, punch_q, sign_delay_q, sign_pending_q,
                             prod_flag_q, second_flag_q, first_flag_q, sign_gate};
  wire [31:0] rd_mux = hit_ctrl   ? {28'h0000000, ctrl_q} :
                       hit_status ? status_word :
                       hit_pos    ? {24'h000000, idx.pos} : 32'h00000000;

  // position counter, frozen while the machine stands
  psc_index_counter #(
    .TICK_DIV (TICK_DIV)
  ) u_idx (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .run_in (feed_run),
    .idx    (idx)
  );

  // apb register writes
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      ctrl_q <= CTRL_RST;
    else if (apb_wr && hit_ctrl)
      ctrl_q <= pwdata_in[CTRL_W-1:0];
  end

  // apb read data, captured in the first access cycle and held for the answer
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      prdata_q <= 32'h00000000;
    else if (apb_rd_take)
      prdata_q <= rd_mux;
  end

  // read handshake; the wait state keeps read data on a flip-flop yet valid at pready
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      rd_ack_q <= 1'b0;
    else
      rd_ack_q <= apb_rd_take;
  end

  // factor and product flags: set at X time, dropped at 5.0
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      first_flag_q  <= 1'b0;
      second_flag_q <= 1'b0;
      prod_flag_q   <= 1'b0;
    end
    else
    begin
      first_flag_q  <= first_set  || (first_flag_q  && !idx.hold_end_evt);
      second_flag_q <= second_set || (second_flag_q && !idx.hold_end_evt);
      prod_flag_q   <= prod_set   || (prod_flag_q   && !idx.hold_end_evt);
    end
  end

  // vote caught as the flags drop, consumed at 6.7
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      sign_pending_q <= 1'b0;
    else if (idx.hold_end_evt)
      sign_pending_q <= sign_vote;
    else if (idx.pickup_evt)
      sign_pending_q <= 1'b0;
  end

  // sign delay: picks at 6.7 on an odd vote, drops at 11.5
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      sign_delay_q <= 1'b0;
    else if (idx.pickup_evt && sign_pending_q)
      sign_delay_q <= 1'b1;
    else if (idx.delay_end_evt)
      sign_delay_q <= 1'b0;
  end

  // product X punch magnet pulse
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      punch_q <= 1'b0;
    else
      punch_q <= punch_fire;
  end

  // check delay set at X time, handed on at 5.0
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      check_delay_q <= 1'b0;
      check_pend_q  <= 1'b0;
    end
    else
    begin
      check_delay_q <= check_fire || (check_delay_q && !idx.hold_end_evt);
      if (idx.hold_end_evt)
        check_pend_q <= check_delay_q;
      else if (idx.pickup_evt)
        check_pend_q <= 1'b0;
    end
  end

  // check error: picks at 6.7 of the next cycle, holds to 11.5
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      check_error_q <= 1'b0;
    else if (idx.pickup_evt && check_pend_q)
      check_error_q <= 1'b1;
    else if (idx.delay_end_evt)
      check_error_q <= 1'b0;
  end

  // error latch: a new error beats a reset in the same clock
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      err_latch_q <= 1'b0;
    else
      err_latch_q <= err_set || (err_latch_q && !err_clr);
  end

  // halt deferred to the end of the second-brush cycle
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      stop_q <= 1'b0;
    else if (idx.cycle_end_evt && err_latch_q)
      stop_q <= 1'b1;
    else if (err_clr)  // a one-clock software reset must release the halt too
      stop_q <= 1'b0;
  end

  // outputs; the light follows the halt, both cleared by error reset
  assign prdata_out             = prdata_q;
  assign pready_out             = apb_acc && (pwrite_in || rd_ack_q);
  assign pslverr_out            = apb_acc && !apb_hit;
  assign product_sign_punch_out = punch_q;
  assign machine_stop_out       = stop_q;
  assign error_light_out        = stop_q;
  assign feed_run_out           = feed_run;

  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  chk_gate_switch_off: assert property (!sign_enable && !factor_flags |=> !factor_flags)
    else $error("factor flag set with sign control off");
  chk_second_flag_set: assert property (sign_gate && second_sel |=> second_flag_q)
    else $error("second factor flag missed its X");
  chk_prod_punch_mode: assert property (!check_mode_relay |=> !$rose(prod_flag_q))
    else $error("product flag set outside check mode");
  chk_flag_hold_end: assert property (idx.hold_end_evt |=> !first_flag_q && !second_flag_q)
    else $error("factor flag survived its hold end");
  chk_vote_parity: assert property (idx.hold_end_evt |=> sign_pending_q == $past(sign_vote))
    else $error("pending sign is not the parity of the flags");
  chk_delay_pick_time: assert property ($rose(sign_delay_q) |-> $past(idx.pickup_evt && sign_pending_q))
    else $error("sign delay picked outside 6.7");
  chk_delay_drop_time: assert property (idx.delay_end_evt && !idx.pickup_evt |=> !sign_delay_q)
    else $error("sign delay held past 11.5");
  chk_delay_needs_vote: assert property (idx.pickup_evt && !sign_pending_q && !sign_delay_q |=> !sign_delay_q)
    else $error("sign delay picked on an even vote");
  chk_punch_x_time: assert property (product_sign_punch_out |->
    $past(idx.x_evt && sign_delay_q && !check_mode_relay))
    else $error("punch outside x time or in check mode");
  chk_check_no_punch: assert property (check_fire |=> check_delay_q && !product_sign_punch_out)
    else $error("check mode punched instead of setting check delay");
  chk_error_at_x: assert property ($rose(err_latch_q) |-> $past(sign_gate && check_error_q))
    else $error("error latch set outside x time of a check error");
  chk_swap_first_flag: assert property (sign_gate && swap_in && multiplier_sign_in |=> first_flag_q)
    else $error("reversal did not route the multiplier X");
  chk_check_error_src: assert property ($rose(check_error_q) |-> $past(idx.pickup_evt && check_pend_q))
    else $error("check error without a prior check delay");
  chk_stop_cycle_end: assert property ($rose(stop_q) |-> $past(idx.cycle_end_evt && err_latch_q))
    else $error("machine stopped before the cycle end");
  chk_stop_waits: assert property (err_latch_q && !stop_q && !idx.cycle_end_evt |=> !stop_q)
    else $error("machine halted before the cycle end");
  chk_stop_freeze: assert property (stop_q |=> $stable(idx.pos))
    else $error("card cycle advanced while halted");
  chk_latch_holds: assert property (err_latch_q && !err_clr |=> err_latch_q)
    else $error("error latch dropped without reset");
  chk_latch_clears: assert property (err_clr && !err_set |=> !err_latch_q)
    else $error("error latch survived an error reset");
  chk_rate_suppress: assert property (rate_card_suppress_in && !err_latch_q |=> !err_latch_q)
    else $error("error latched during a rate card");

  cov_punch_negative: cover property (product_sign_punch_out);
  cov_check_stop: cover property ($rose(stop_q));
  cov_check_agree: cover property (check_mode_relay && prod_flag_q && first_flag_q ##1 idx.hold_end_evt);
  cov_error_reset: cover property ($fell(stop_q));
  cov_reversed_check: cover property (swap_in && check_fire);
endmodule : psc_sign_top

/* File: psc_brush_model.sv */
// Purpose: card brush model facing the sign block, shows X holes near X time
// Assumes: one card per card cycle, position tracked the same way as the block
// Notes:   an unpunched brush is an open contact and so reads low
module psc_brush_model
#(
  parameter int unsigned CYC = 160  // clocks per card cycle at one tenth per clock
)(
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // feed state and card content {product, multiplier, multiplicand}
  input  wire logic       feed_run_in,
  input  wire logic [2:0] card_in,
  // brushes and cycle position
  output logic [2:0]      brush_out,
  output logic [7:0]      pos_out
);
  // position advances only while cards are fed, so a stop freezes it too
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      pos_out <= 8'h00;
    else if (feed_run_in)
      pos_out <= (pos_out == 8'(CYC - 1)) ? 8'h00 : pos_out + 8'h01;
  end
  // the hole passes the brush around the X row only; any column may carry it
  // a wide window tolerates a one-clock offset against the block's counter
  assign brush_out = (pos_out >= 8'h64 && pos_out <= 8'h7D) ? card_in : 3'h0;
endmodule : psc_brush_model

/* File: test_product_sign_punch_and_check.sv */
// Purpose: self-checking bench for the product sign punch and check block
// Assumes: one tenth per clock, so a card cycle is 160 clocks
// Notes:   expectations come from a queue of the cards fed so far
module test_product_sign_punch_and_check;
  timeunit 1ns;
  timeprecision 1ps;
  // control words: sign off, punch mode, check mode, check with reversal
  localparam logic [3:0] MODES [4] = '{4'h8, 4'h9, 4'hB, 4'hF};
  // stimulus and observed signals
  logic        clk_in  = 1'b0;
  logic        rst_in  = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [31:0] paddr   = 32'h0;
  logic [31:0] pwdata  = 32'h0;
  logic        supp    = 1'b0;
  logic        err_rst = 1'b0;
  logic [2:0]  card    = 3'h0;  // {product, multiplier, multiplicand}
  logic [31:0] prdata, rd;
  logic [2:0]  brush;
  logic [7:0]  pos;
  logic        pready, pslverr, er, punch, stop, light, run;
  logic [3:0]  ctrl    = 4'h0;  // bench copy of the control register
  logic        use_cmd = 1'b0;  // alternates the two error reset paths
  int          fails = 0;
  int          tests_run = 0;
  int          seed = 77752;
  logic [2:0]  hist[$];         // card read in each cycle
  // free running 100 MHz clock
  initial
  begin
    forever #5 clk_in = ~clk_in;
  end
  // block under test, short tick so a card cycle is 160 clocks
  psc_sign_top #(.TICK_DIV(1)) dut_u (
    .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .multiplicand_sign_in(brush[0]),
    .multiplier_sign_in(brush[1]), .product_sign_check_in(brush[2]),
    .rate_card_suppress_in(supp), .error_reset_in(err_rst), .product_sign_punch_out(punch),
    .machine_stop_out(stop), .error_light_out(light), .feed_run_out(run));
  // brushes on the far side
  psc_brush_model brush_u (
    .clk_in(clk_in), .rst_in(rst_in), .feed_run_in(run), .card_in(card),
    .brush_out(brush), .pos_out(pos));
  // verdict and end of run
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results
  // one value comparison, four-state exact
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask : check
  // a wait that ran out ends the run
  task automatic timeout();
    fails++;
    $display("mismatch at %0t: wait ran out", $time);
    results();
  endtask : timeout
  // apb transfer; request held until pready is seen high, read data taken at that edge
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_in);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk_in);
      if (pready === 1'b1)
        break;
    end
    if (n == 20)
      timeout();
    er = pslverr;
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // write the control register and read it back
  task automatic set_ctrl(input logic [3:0] v);
    ctrl = v;
    apb(1'b1, 32'h0, {28'h0, v});
    apb(1'b0, 32'h0, 32'h0);
    check(rd, {28'h0, v}, "control readback");
  endtask : set_ctrl
  // one card cycle: present a card, count punches, then check stop and the held flags
  task automatic feed(input logic [2:0] c, input logic s);
    int         n;
    int         np;
    logic [2:0] h1;
    logic [2:0] h2;
    logic [2:0] fl;
    logic       pe;
    logic       se;
    logic       sw;
    @(posedge clk_in);
    card <= c;
    supp <= s;
    hist.push_back(c);
    h1 = hist[hist.size() - 2];
    h2 = hist[hist.size() - 3];
    pe = ctrl[0] & ~ctrl[1] & (h1[0] ^ h1[1]);
    se = ctrl[0] & ctrl[1] & ~s & ((h2[0] ^ h2[1]) != h2[2]);
    sw = ctrl[1] & ctrl[2];
    fl = ctrl[0] ? {ctrl[1] & c[2], sw ? c[0] : c[1], sw ? c[1] : c[0]} : 3'h0;
    np = 0;
    for (n = 0; n < 400; n++)
    begin
      @(negedge clk_in);
      if (punch === 1'b1)
      begin
        np++;
        check({31'h0, pos >= 8'h6E && pos <= 8'h70}, 32'h1, "punch position");
      end
      if (pos === 8'h9F)
        break;
    end
    if (n == 400)
      timeout();
    check(32'(np), {31'h0, pe}, "punch count");
    @(negedge clk_in);
    check({29'h0, stop, light, run}, {29'h0, se, se, ~se}, "stop");
    apb(1'b0, 32'h4, 32'h0);
    check({29'h0, rd[3:1]}, {29'h0, fl}, "factor flags");
    if (se)
    begin
      repeat (20) @(negedge clk_in);
      check({31'h0, light}, 32'h1, "latch held");
      if (use_cmd)
        apb(1'b1, 32'h8, 32'h1);
      else
      begin
        @(posedge clk_in);
        err_rst <= 1'b1;
        repeat (2) @(posedge clk_in);
        err_rst <= 1'b0;
      end
      repeat (3) @(negedge clk_in);
      check({30'h0, stop, light}, 32'h0, "reset cleared");
      use_cmd = ~use_cmd;
    end
  endtask : feed
  // main sequence
  initial
  begin
    int         i;
    int         k;
    logic [2:0] cv;
    hist.push_back(3'h0);
    hist.push_back(3'h0);
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    // reset values of the four registers, then one unmapped word
    for (i = 0; i < 5; i++)
    begin
      apb(1'b0, 32'(i * 4), 32'h0);
      check(rd, 32'h0, "reset value");
      check({31'h0, er}, 32'(i == 4), "slave error");
    end
    // random cards in each mode, flushed with blank cards before the next
    for (i = 0; i < 4; i++)
    begin
      set_ctrl(MODES[i]);
      for (k = 0; k < 10; k++)
      begin
        cv = 3'($random(seed));
        feed(cv, 1'b0);
      end
      feed(3'h0, 1'b0);
      feed(3'h0, 1'b0);
    end
    // a wrong product sign while a rate card blocks the error latch
    feed(3'h1, 1'b0);
    feed(3'h0, 1'b0);
    feed(3'h0, 1'b1);
    feed(3'h0, 1'b0);
    results();
  end
endmodule : test_product_sign_punch_and_check
